// ==== ocst_pkg.sv ====
// package: constants and types for the output compare block
package ocst_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int OCST_CNT_W = 16;
	localparam int OCST_SEL_W = 5;
	localparam int OCST_CLK_W = 3;
	localparam int OCST_MODE_W = 2;
	localparam int OCST_SRC_N = 32;
	// ----------------------------------------
	// control register two field positions
	// ----------------------------------------
	localparam int OCST_SEL_LSB = 0;
	localparam int OCST_TRIG_BIT = 7;
	localparam int OCST_CASC_BIT = 8;
	localparam int OCST_CTL_W = 9;
	// ----------------------------------------
	// values
	// ----------------------------------------
	localparam logic [OCST_CNT_W-1:0] OCST_CNT_ZERO = 16'h0000;
	localparam logic [OCST_CNT_W-1:0] OCST_CNT_ONE = 16'h0001;
	localparam logic [OCST_CNT_W-1:0] OCST_CNT_MAX = 16'hFFFF;
	localparam logic [OCST_SEL_W-1:0] OCST_SEL_FREE = 5'h00;
	localparam logic [OCST_CLK_W-1:0] OCST_CLK_NUM = 3'h6;
	// ----------------------------------------
	// output generation modes
	// ----------------------------------------
	typedef enum logic [OCST_MODE_W-1:0] {
		OCST_OUT_OFF = 2'h0,
		OCST_OUT_SINGLE = 2'h1,
		OCST_OUT_CONT = 2'h2,
		OCST_OUT_PWM = 2'h3
	} ocst_out_type;
	// ----------------------------------------
	// counter run states, one-hot
	// ----------------------------------------
	typedef enum logic [2:0] {
		OCST_ST_FREE = 3'h1,
		OCST_ST_SYNC = 3'h2,
		OCST_ST_WAIT = 3'h4
	} ocst_state_type;
endpackage

// ==== ocst_tick_if.sv ====
// interface: counter advance tick and sync strobe between the front end and the core
`timescale 1ns/1ps
`default_nettype none
interface ocst_tick_if;
	logic tick;
	logic sync;
	modport src (output tick, output sync);
	modport dst (input tick, input sync);
endinterface
`default_nettype wire

// ==== ocst_clksel.sv ====
// module: clock source and sync source selection front end
`timescale 1ns/1ps
`default_nettype none
module ocst_clksel
(
	input wire logic [5:0] i_clk_src,
	input wire logic [ocst_pkg::OCST_CLK_W-1:0] i_clk_select,
	input wire logic [ocst_pkg::OCST_SRC_N-1:0] i_sync_src,
	input wire logic [ocst_pkg::OCST_SEL_W-1:0] i_sync_select,
	ocst_tick_if.src tk
);
	import ocst_pkg::*;
	// ----------------------------------------
	// selection
	// ----------------------------------------
	// codes at or above the source count give no tick, so the counter holds
	wire clk_valid = i_clk_select < OCST_CLK_NUM;
	assign tk.tick = clk_valid && i_clk_src[i_clk_select]; // see R16
	// index zero is the free-running code and never syncs
	assign tk.sync = (i_sync_select != OCST_SEL_FREE) && i_sync_src[i_sync_select]; // see R9
endmodule
`default_nettype wire

// ==== ocst_core.sv ====
// module: output compare core with dedicated counter, sync/trigger and cascade
// ----------------------------------------
// Operation
// R1: free-running counter counts up and wraps FFFF to 0000
// R2: event when counter equals primary or secondary period value
// R3: synchronous mode runs at once when clock source is enabled
// R4: synchronous mode clears counter on every sync event
// R5: trigger mode holds counter until a sync event, then runs
// R6: free-running after reset and whenever sync source select is zero
// R7: trigger mode select bit 7 chooses trigger mode for nonzero select
// R8: bit 7 clear with nonzero select gives synchronous mode
// R9: sync source select picks which internal event syncs or triggers
// R10: by default module runs alone with its own 16-bit counter
// R11: cascade pairs adjacent odd and even modules
// R12: odd module holds low half, even module high half
// R13: low half wrap increments the high half
// R14: software sets cascade enable bit 8 in both modules of the pair
// R15: single pulse, continuous pulse and PWM generation supported
// R16: up to six clock sources drive the counter
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ocst_core
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic I_CLK_EN,
	input wire logic [ocst_pkg::OCST_CTL_W-1:0] I_CONTROL_TWO,
	input wire logic I_HIGH_HALF,
	input wire logic [ocst_pkg::OCST_CLK_W-1:0] I_CLK_SELECT,
	input wire logic [5:0] I_CLK_SRC,
	input wire logic [ocst_pkg::OCST_SRC_N-1:0] I_SYNC_SRC,
	input wire ocst_pkg::ocst_out_type I_OUT_MODE,
	input wire logic I_ARM,
	input wire logic [ocst_pkg::OCST_CNT_W-1:0] I_PRIMARY_PERIOD_VALUE,
	input wire logic [ocst_pkg::OCST_CNT_W-1:0] I_SECONDARY_PERIOD_VALUE,
	input wire logic I_CASCADE_WRAP,
	input wire logic I_CASCADE_MATCH,
	output logic [ocst_pkg::OCST_CNT_W-1:0] O_COMPARE_COUNTER,
	output logic O_WRAP,
	output logic O_MATCH,
	output logic O_EVENT,
	output logic O_OUT,
	output logic O_RUNNING
);
	import ocst_pkg::*;
	// ----------------------------------------
	// control decode
	// ----------------------------------------
	wire [OCST_SEL_W-1:0] sync_source_select = I_CONTROL_TWO[OCST_SEL_LSB +: OCST_SEL_W];
	wire trigger_mode_select = I_CONTROL_TWO[OCST_TRIG_BIT];
	wire cascade_enable = I_CONTROL_TWO[OCST_CASC_BIT];
	wire free_mode = sync_source_select == OCST_SEL_FREE; // see R6
	wire trig_mode = !free_mode && trigger_mode_select; // see R7
	wire sync_mode = !free_mode && !trigger_mode_select; // see R8
	wire casc_high = cascade_enable && I_HIGH_HALF; // see R11
	ocst_tick_if tk ();
	ocst_clksel u_sel
	(
		.i_clk_src(I_CLK_SRC),
		.i_clk_select(I_CLK_SELECT),
		.i_sync_src(I_SYNC_SRC),
		.i_sync_select(sync_source_select),
		.tk(tk)
	);
	// ----------------------------------------
	// run state
	// ----------------------------------------
	ocst_state_type state_q;
	ocst_state_type state_d;
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			OCST_ST_FREE:
			begin
				if (sync_mode)
					state_d = OCST_ST_SYNC;
				else if (trig_mode)
					state_d = OCST_ST_WAIT; // see R5
			end
			OCST_ST_SYNC:
			begin
				if (free_mode)
					state_d = OCST_ST_FREE;
				else if (trig_mode)
					state_d = OCST_ST_WAIT;
			end
			OCST_ST_WAIT:
			begin
				if (free_mode)
					state_d = OCST_ST_FREE;
				else if (sync_mode)
					state_d = OCST_ST_SYNC;
			end
			default:
				state_d = OCST_ST_FREE;
		endcase
	end
	// trigger mode latches a run flag; the waiting state itself stays put so
	// that leaving trigger mode always re-arms on the next entry
	logic armed_q;
	logic armed_d;
	wire in_wait = state_q == OCST_ST_WAIT;
	assign armed_d = !in_wait ? 1'b0 : (armed_q || tk.sync); // see R5
	// ----------------------------------------
	// counter advance
	// ----------------------------------------
	// sync mode needs no event to start: it runs as soon as ticks arrive
	wire run_ok = (state_q != OCST_ST_WAIT) || armed_q; // see R3
	// high half advances only on the low half's wrap
	wire adv = run_ok && (casc_high ? I_CASCADE_WRAP : tk.tick); // see R13
	wire sync_clr = (state_q == OCST_ST_SYNC) && tk.sync; // see R4
	function automatic logic [OCST_CNT_W-1:0] ocst_inc(input logic [OCST_CNT_W-1:0] v);
		ocst_inc = v + OCST_CNT_ONE;
	endfunction
	logic [OCST_CNT_W-1:0] cnt_q;
	logic [OCST_CNT_W-1:0] cnt_d;
	assign cnt_d = sync_clr ? OCST_CNT_ZERO : (adv ? ocst_inc(cnt_q) : cnt_q); // see R1
	wire wrap = adv && !sync_clr && (cnt_q == OCST_CNT_MAX); // see R1
	// ----------------------------------------
	// compare and output
	// ----------------------------------------
	wire m_pri = cnt_q == I_PRIMARY_PERIOD_VALUE; // see R2
	wire m_sec = cnt_q == I_SECONDARY_PERIOD_VALUE; // see R2
	// in a pair the high half's match only counts while the low half matches too
	wire m_any = m_pri || m_sec;
	wire match_ok = casc_high ? (m_any && I_CASCADE_MATCH) : (cascade_enable ? m_any : m_any); // see R12
	// one event per count value, not per clock cycle
	logic cnt_new_q;
	wire evt = match_ok && cnt_new_q && run_ok; // see R2
	wire pri_evt = evt && m_pri;
	wire sec_evt = evt && m_sec;
	logic out_d;
	logic done_q;
	logic done_d;
	always_comb
	begin
		out_d = O_OUT;
		done_d = done_q;
		if (I_ARM)
			done_d = 1'b0;
		case (I_OUT_MODE)
			OCST_OUT_SINGLE:
			begin
				if (pri_evt && !done_q)
					out_d = 1'b1;
				if (sec_evt && O_OUT)
				begin
					out_d = 1'b0;
					done_d = 1'b1;
				end
			end
			OCST_OUT_CONT:
			begin
				if (pri_evt)
					out_d = 1'b1;
				if (sec_evt)
					out_d = 1'b0;
			end
			OCST_OUT_PWM:
			begin
				// rising at the primary value, falling at the secondary (duty)
				if (pri_evt)
					out_d = 1'b1;
				if (sec_evt)
					out_d = 1'b0;
				if (pri_evt && m_sec)
					out_d = 1'b0;
			end
			default:
				out_d = 1'b0;
		endcase
	end // see R15
	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			state_q <= OCST_ST_FREE; // see R6
			armed_q <= 1'b0;
			cnt_q <= OCST_CNT_ZERO;
			cnt_new_q <= 1'b1;
			done_q <= 1'b0;
			O_OUT <= 1'b0;
			O_WRAP <= 1'b0;
			O_EVENT <= 1'b0;
		end
		else if (I_CLK_EN)
		begin
			state_q <= state_d;
			armed_q <= armed_d;
			cnt_q <= cnt_d; // see R10
			cnt_new_q <= adv || sync_clr;
			done_q <= done_d;
			O_OUT <= out_d;
			O_WRAP <= wrap;
			O_EVENT <= evt;
		end
	end
	assign O_COMPARE_COUNTER = cnt_q;
	assign O_MATCH = m_any && run_ok;
	assign O_RUNNING = run_ok;
endmodule
`default_nettype wire

// ==== ocst_props.sv ====
// checker: timing properties of the output compare core
`timescale 1ns/1ps
`default_nettype none
module ocst_props
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic I_CLK_EN,
	input wire logic [ocst_pkg::OCST_CTL_W-1:0] I_CONTROL_TWO,
	input wire logic I_HIGH_HALF,
	input wire logic [ocst_pkg::OCST_CLK_W-1:0] I_CLK_SELECT,
	input wire logic [5:0] I_CLK_SRC,
	input wire logic [ocst_pkg::OCST_SRC_N-1:0] I_SYNC_SRC,
	input wire ocst_pkg::ocst_out_type I_OUT_MODE,
	input wire logic [15:0] I_PRIMARY_PERIOD_VALUE,
	input wire logic [15:0] I_SECONDARY_PERIOD_VALUE,
	input wire logic [15:0] O_COMPARE_COUNTER,
	input wire logic O_WRAP,
	input wire logic O_MATCH,
	input wire logic O_EVENT,
	input wire logic O_OUT,
	input wire logic O_RUNNING
);
	import ocst_pkg::*;
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_B);
	// selects 6 and 7 mean no clock, so the index is guarded first
	wire logic tick = I_CLK_EN && I_CLK_SELECT < 3'h6 && I_CLK_SRC[I_CLK_SELECT];
	wire logic [4:0] sel = I_CONTROL_TWO[4:0];
	wire logic hit = I_SYNC_SRC[sel];
	wire logic solo = !I_HIGH_HALF && !I_CONTROL_TWO[8];
	wire logic [15:0] c = O_COMPARE_COUNTER;
	wire logic eq = c == I_PRIMARY_PERIOD_VALUE || c == I_SECONDARY_PERIOD_VALUE;
	a_free_count: assert property (solo && sel == 5'h00 && tick && $stable(I_CONTROL_TWO) |=> c == $past(c) + 16'h0001)
		else $error("free count did not advance");
	a_wrap_flag: assert property (solo && sel == 5'h00 && tick && c == 16'hFFFF |-> ##[1:2] O_WRAP)
		else $error("wrap flag missing");
	a_wrap_once: assert property (O_WRAP && I_CLK_EN |=> !O_WRAP)
		else $error("wrap flag too long");
	a_match_now: assert property (!I_HIGH_HALF |-> O_MATCH == (O_RUNNING && eq))
		else $error("match flag wrong");
	a_event_cause: assert property (O_EVENT && !I_HIGH_HALF |-> $past(O_MATCH))
		else $error("event without match");
	a_sync_clear: assert property (solo && sel != 5'h00 && !I_CONTROL_TWO[7] && I_CLK_EN && hit
		&& $stable(I_CONTROL_TWO) |=> c == 16'h0000)
		else $error("sync did not clear count");
	a_trig_hold: assert property (!O_RUNNING && !hit && I_CLK_EN |=> $stable(c))
		else $error("count moved while waiting");
	a_trig_start: assert property (!O_RUNNING && hit && I_CLK_EN && I_CONTROL_TWO[7]
		&& $stable(I_CONTROL_TWO) |=> O_RUNNING)
		else $error("trigger did not start count");
	a_free_run: assert property ((sel == 5'h00 && I_CLK_EN) [*2] |-> O_RUNNING)
		else $error("free mode not running");
	a_pwm_level: assert property (I_OUT_MODE == OCST_OUT_PWM && O_EVENT && $past(c) == I_PRIMARY_PERIOD_VALUE
		&& I_PRIMARY_PERIOD_VALUE != I_SECONDARY_PERIOD_VALUE |-> O_OUT)
		else $error("pwm level not set");
	c_wrap: cover property (O_WRAP);
	c_trig: cover property (!O_RUNNING ##1 O_RUNNING);
	c_pwm: cover property (O_EVENT && O_OUT);
endmodule
`default_nettype wire

// ==== ocst_far_src.sv ====
// partner: internal module that pulses one sync line every 16 cycles
`timescale 1ns/1ps
`default_nettype none
module ocst_far_src
(
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [4:0] i_idx,
	output logic [31:0] o_sync
);
	logic [3:0] cnt_q;
	always_ff @(posedge i_clk)
	begin
		cnt_q <= i_go ? cnt_q + 4'h1 : 4'h0;
		o_sync <= (i_go && cnt_q == 4'hF) ? 32'h1 << i_idx : 32'h0;
	end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// testbench: output compare core with an expected-event queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ocst_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, cke = 1'b1, arm = 1'b0, wrap, match, ev, out, run;
	logic [8:0] ctl = 9'h000;
	logic [2:0] csel = 3'h0;
	logic [5:0] src = 6'h3F;
	logic [4:0] idx = 5'h01;
	logic [15:0] pv = 16'h0000, sv = 16'h0000, p, cnt, snap;
	logic [31:0] sync;
	ocst_out_type mode = OCST_OUT_PWM;
	logic [15:0] expq[$];
	int miscompares = 0, tests_run = 0, cyc = 0;
	initial forever #12.5 clk = ~clk;
	ocst_far_src i_far (.i_clk(clk), .i_go(go), .i_idx(idx), .o_sync(sync));
	ocst_core i_dut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CLK_EN(cke), .I_CONTROL_TWO(ctl),
		.I_HIGH_HALF(1'b0), .I_CLK_SELECT(csel), .I_CLK_SRC(src), .I_SYNC_SRC(sync), .I_OUT_MODE(mode),
		.I_ARM(arm), .I_PRIMARY_PERIOD_VALUE(pv), .I_SECONDARY_PERIOD_VALUE(sv), .I_CASCADE_WRAP(1'b0),
		.I_CASCADE_MATCH(1'b0), .O_COMPARE_COUNTER(cnt), .O_WRAP(wrap), .O_MATCH(match), .O_EVENT(ev),
		.O_OUT(out), .O_RUNNING(run));
	task automatic chk(input string what, input logic [15:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic restart(input logic [8:0] c, input logic [15:0] a, b);
		rst_b <= 1'b0;
		go <= 1'b0;
		cke <= 1'b1;
		ctl <= c;
		pv <= a;
		sv <= b;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
	endtask
	task automatic expect_pwm(input int n);
		repeat (n)
		begin
			expq.push_back(16'h0001);
			expq.push_back(16'h0000);
		end
	endtask
	task automatic drain(input int lim);
		repeat (lim) if (expq.size() != 0) @(posedge clk);
		chk("events left", 16'h0000, 16'(expq.size()));
	endtask
	// events are taken at the falling edge, where registered outputs have settled
	always @(negedge clk)
	begin
		cyc++;
		if (cyc > 90000)
		begin
			miscompares++;
			print_verdict();
		end
		if (rst_b && ev === 1'b1)
			chk("event level", expq.size() ? expq.pop_front() : 16'hDEAD, {15'h0, out});
		if (rst_b && wrap === 1'b1)
			chk("wrap count", 16'h0000, cnt);
	end
	// ----
	// scenarios: sync, trigger, single pulse, free run with wrap
	// ----
	initial
	begin
		void'($urandom(32'h50771b2e));
		idx = 5'($urandom_range(31, 1));
		csel = 3'($urandom_range(5, 0));
		p = 16'($urandom_range(7, 2));
		restart({4'h0, idx}, p, p + 16'h0004);
		go <= 1'b1;
		expect_pwm(5);
		drain(200);
		restart({4'h4, idx}, p, p + 16'h0004);
		repeat (20) @(negedge clk);
		snap = cnt;
		@(posedge clk);
		cke <= 1'($urandom);
		repeat (10) @(negedge clk);
		chk("held count", snap, cnt);
		chk("running", 16'h0000, {15'h0, run});
		@(posedge clk);
		go <= 1'b1;
		cke <= 1'b1;
		expect_pwm(1);
		drain(100);
		chk("running", 16'h0001, {15'h0, run});
		// single pulse in a pair's low half: one pulse, then silent until re-armed
		restart({4'h8, idx}, p, p + 16'h0004);
		mode <= OCST_OUT_SINGLE;
		go <= 1'b1;
		expq.push_back(16'h0001);
		repeat (3) expq.push_back(16'h0000);
		drain(100);
		@(posedge clk);
		arm <= 1'b1;
		@(posedge clk);
		arm <= 1'b0;
		expect_pwm(1);
		drain(100);
		// sync pulses keep coming here and must be ignored
		restart(9'h000, 16'h0003, 16'hFFFF);
		mode <= OCST_OUT_PWM;
		go <= 1'b1;
		expect_pwm(1);
		expq.push_back(16'h0001);
		drain(70000);
		print_verdict();
	end
endmodule
bind ocst_core ocst_props i_props (.I_CORE_CLK, .I_RST_B, .I_CLK_EN, .I_CONTROL_TWO, .I_HIGH_HALF,
	.I_CLK_SELECT, .I_CLK_SRC, .I_SYNC_SRC, .I_OUT_MODE, .I_PRIMARY_PERIOD_VALUE, .I_SECONDARY_PERIOD_VALUE,
	.O_COMPARE_COUNTER, .O_WRAP, .O_MATCH, .O_EVENT, .O_OUT, .O_RUNNING);
`default_nettype wire
